// >>> src/tone_curve_pkg.sv
package tone_curve_pkg;
	// Pixel and component geometry
	localparam int PIX_IN_W = 36;
	localparam int PIX_OUT_W = 30;
	localparam int COMP_IN_W = 12;
	localparam int COMP_OUT_W = 10;
	localparam int NUM_COMP = 3;
	localparam int IDX_W = 6;
	localparam int FRAC_W = 6;
	localparam int ENTRIES = 64;
	localparam int SLOPE_W = 10;
	localparam int CONST_W = 10;
	localparam int ENTRY_W = SLOPE_W + CONST_W;
	localparam int TRUNC_DROP = 2;
	localparam logic [COMP_OUT_W-1:0] OUT_MAX = 10'h3FF;

	// Entry register field layout
	localparam int SLOPE_LSB = 0;
	localparam int CONST_LSB = 16;

	// Buffering
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_CNT_W = 5;

	// AXI4-Lite register map (byte addresses)
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 32'hF000_8080;
	localparam logic [ADDR_W-1:0] ADDR_INDEX = 32'hF000_8084;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 32'hF000_8088;
	localparam logic [ADDR_W-1:0] ADDR_IN_COUNT = 32'hF000_808C;
	localparam logic [ADDR_W-1:0] ADDR_RED = 32'hF000_8090;
	localparam logic [ADDR_W-1:0] ADDR_GREEN = 32'hF000_8094;
	localparam logic [ADDR_W-1:0] ADDR_BLUE = 32'hF000_8098;
	localparam logic [ADDR_W-1:0] ADDR_OUT_COUNT = 32'hF000_809C;

	// Control and status fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_XSEL_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [IDX_W-1:0] INDEX_RESET = 6'h00;
	localparam int STAT_LEVEL_LSB = 0;
	localparam int STAT_BUSY_BIT = 8;
	localparam int STAT_WHILE_EN_BIT = 9;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_BYPASS = 2'b00,
		MODE_TRUNC = 2'b01,
		MODE_INTERP = 2'b10
	} curve_mode_e;
endpackage : tone_curve_pkg

// >>> src/pixel_stream_if.sv
`timescale 1ns/1ps
interface pixel_stream_if #(parameter int WIDTH = 30);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : pixel_stream_if

// >>> src/pixel_fifo.sv
`timescale 1ns/1ps
module pixel_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Streams
	pixel_stream_if.snk fill,
	pixel_stream_if.src drain,
	// Occupancy
	output logic [CNT_W-1:0] level
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	logic push;
	logic pop;

	assign fill.ready = (count != CNT_W'(DEPTH));
	assign drain.valid = (count != '0);
	assign drain.data = mem[rd_ptr];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;
	assign level = count;

	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wr_ptr] <= fill.data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + PTR_W'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + PTR_W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + CNT_W'(1);
		end else if (pop && !push) begin
			count <= count - CNT_W'(1);
		end
	end
endmodule : pixel_fifo

// >>> src/tone_curve_interpolator.sv
`timescale 1ns/1ps
module tone_curve_interpolator (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [tone_curve_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [tone_curve_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [tone_curve_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [tone_curve_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// Colour-corrected pixel input
	input wire logic color_corrected_valid,
	output logic color_corrected_ready,
	input wire logic [tone_curve_pkg::PIX_IN_W-1:0] color_corrected_pixel,
	// Tone-mapped pixel output
	output logic tone_valid,
	input wire logic tone_ready,
	output logic [tone_curve_pkg::PIX_OUT_W-1:0] tone_pixel
);
	import tone_curve_pkg::*;

	// Control state
	logic [1:0] curve_control_register;
	logic [IDX_W-1:0] entry_index;
	logic write_while_enabled;
	logic [DATA_W-1:0] in_count;
	logic [DATA_W-1:0] out_count;

	// Write channel state
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	logic [NUM_COMP-1:0] table_we;
	logic [ENTRY_W-1:0] table_wdata;
	logic [DATA_W-1:0] entry_word [NUM_COMP];
	logic write_hit;

	// Read mux
	logic [DATA_W-1:0] read_word;
	logic read_hit;

	// Pixel pipeline
	logic advance;
	logic stage1_valid;
	logic [PIX_IN_W-1:0] stage1_pixel;
	curve_mode_e stage1_mode;
	curve_mode_e next_mode;
	logic stage2_valid;
	logic [PIX_OUT_W-1:0] stage2_pixel;
	logic [PIX_OUT_W-1:0] next_pixel;
	logic [COMP_OUT_W-1:0] interp_result [NUM_COMP];
	logic [FIFO_CNT_W-1:0] fifo_level;

	pixel_stream_if #(.WIDTH(PIX_OUT_W)) fifo_fill ();
	pixel_stream_if #(.WIDTH(PIX_OUT_W)) fifo_drain ();

	function automatic logic [DATA_W-1:0] merge_bytes(
		input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word,
		input logic [3:0] strb
	);
		logic [DATA_W-1:0] merged;
		merged = old_word;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merged[b*8 +: 8] = new_word[b*8 +: 8];
			end
		end
		return merged;
	endfunction : merge_bytes

	// Slope is a signed 10-bit integer, so the product carries six fraction bits
	function automatic logic [COMP_OUT_W-1:0] interpolate(
		input logic [ENTRY_W-1:0] entry,
		input logic [FRAC_W-1:0] frac
	);
		logic signed [16:0] product;
		logic signed [12:0] sum;
		product = $signed(entry[SLOPE_W-1:0]) * $signed({1'b0, frac});
		sum = $signed({3'b000, entry[ENTRY_W-1:SLOPE_W]})
			+ 13'(product >>> FRAC_W);
		if (sum < 0) begin
			return '0;
		end else if (sum > $signed({3'b000, OUT_MAX})) begin
			return OUT_MAX;
		end else begin
			return sum[COMP_OUT_W-1:0];
		end
	endfunction : interpolate

	// AXI4-Lite write path: address and data taken in either order
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign do_write = aw_held && w_held && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr_q <= '0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		write_hit = 1'b0;
		case (aw_addr_q)
			ADDR_CTRL, ADDR_INDEX, ADDR_STATUS,
			ADDR_RED, ADDR_GREEN, ADDR_BLUE: write_hit = 1'b1;
			default: write_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			curve_control_register <= CTRL_RESET;
		end else if (do_write && aw_addr_q == ADDR_CTRL && w_strb_q[0]) begin
			curve_control_register <= w_data_q[1:0];
		end
	end

	// Table index advances after each entry write for burst loading
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			entry_index <= INDEX_RESET;
		end else if (do_write && aw_addr_q == ADDR_INDEX && w_strb_q[0]) begin
			entry_index <= w_data_q[IDX_W-1:0];
		end else if (|table_we) begin
			entry_index <= entry_index + IDX_W'(1);
		end
	end

	assign table_we[0] = do_write && aw_addr_q == ADDR_RED;
	assign table_we[1] = do_write && aw_addr_q == ADDR_GREEN;
	assign table_we[2] = do_write && aw_addr_q == ADDR_BLUE;

	always_comb begin
		logic [DATA_W-1:0] old_word;
		logic [DATA_W-1:0] merged;
		old_word = '0;
		for (int c = 0; c < NUM_COMP; c++) begin
			if (table_we[c]) begin
				old_word = entry_word[c];
			end
		end
		merged = merge_bytes(old_word, w_data_q, w_strb_q);
		table_wdata = {merged[CONST_LSB +: CONST_W],
			merged[SLOPE_LSB +: SLOPE_W]};
	end

	// Loading while enabled is still performed but flagged, since pixels
	// in flight may then mix old and new entries; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_while_enabled <= 1'b0;
		end else if ((|table_we) && curve_control_register[CTRL_ENABLE_BIT]) begin
			write_while_enabled <= 1'b1;
		end else if (do_write && aw_addr_q == ADDR_STATUS
			&& w_strb_q[1] && w_data_q[STAT_WHILE_EN_BIT]) begin
			write_while_enabled <= 1'b0;
		end
	end

	// AXI4-Lite read path
	assign arready = !rvalid;

	always_comb begin
		read_word = '0;
		read_hit = 1'b1;
		case (araddr)
			ADDR_CTRL: read_word = {30'h0, curve_control_register};
			ADDR_INDEX: read_word = {26'h0, entry_index};
			ADDR_STATUS: begin
				read_word[STAT_LEVEL_LSB +: FIFO_CNT_W] = fifo_level;
				read_word[STAT_BUSY_BIT] = stage1_valid || stage2_valid
					|| fifo_level != '0;
				read_word[STAT_WHILE_EN_BIT] = write_while_enabled;
			end
			ADDR_IN_COUNT: read_word = in_count;
			ADDR_OUT_COUNT: read_word = out_count;
			ADDR_RED: read_word = entry_word[0];
			ADDR_GREEN: read_word = entry_word[1];
			ADDR_BLUE: read_word = entry_word[2];
			default: read_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= read_word;
			rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// Per-colour tables, red first, each 64 entries deep
	for (genvar c = 0; c < NUM_COMP; c++) begin : g_color
		logic [ENTRY_W-1:0] per_color_curve_table [ENTRIES];
		logic [COMP_IN_W-1:0] component;
		logic [ENTRY_W-1:0] selected;

		always_ff @(posedge aclk) begin
			if (table_we[c]) begin
				per_color_curve_table[entry_index] <= table_wdata;
			end
		end

		assign entry_word[c] = {6'h00,
			per_color_curve_table[entry_index][ENTRY_W-1:SLOPE_W],
			6'h00, per_color_curve_table[entry_index][SLOPE_W-1:0]};
		assign component = stage1_pixel[PIX_IN_W-1-c*COMP_IN_W -: COMP_IN_W];
		assign selected = per_color_curve_table[component[COMP_IN_W-1 -: IDX_W]];
		assign interp_result[c] = interpolate(selected, component[FRAC_W-1:0]);
	end

	// Pixel pipeline: two register stages then the FIFO
	assign advance = !stage2_valid || fifo_fill.ready;
	assign color_corrected_ready = advance;

	always_comb begin
		if (!curve_control_register[CTRL_ENABLE_BIT]) begin
			next_mode = MODE_BYPASS;
		end else if (curve_control_register[CTRL_XSEL_BIT]) begin
			next_mode = MODE_INTERP;
		end else begin
			next_mode = MODE_TRUNC;
		end
	end

	// Mode travels with the pixel so a control write never splits one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1_valid <= 1'b0;
			stage1_pixel <= '0;
			stage1_mode <= MODE_BYPASS;
		end else if (advance) begin
			stage1_valid <= color_corrected_valid;
			if (color_corrected_valid) begin
				stage1_pixel <= color_corrected_pixel;
				stage1_mode <= next_mode;
			end
		end
	end

	always_comb begin
		next_pixel = '0;
		case (stage1_mode)
			MODE_BYPASS: next_pixel = stage1_pixel[PIX_OUT_W-1:0];
			MODE_TRUNC: begin
				for (int c = 0; c < NUM_COMP; c++) begin
					next_pixel[PIX_OUT_W-1-c*COMP_OUT_W -: COMP_OUT_W] =
						stage1_pixel[PIX_IN_W-1-c*COMP_IN_W -: COMP_OUT_W];
				end
			end
			MODE_INTERP: begin
				for (int c = 0; c < NUM_COMP; c++) begin
					next_pixel[PIX_OUT_W-1-c*COMP_OUT_W -: COMP_OUT_W] =
						interp_result[c];
				end
			end
			default: next_pixel = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage2_valid <= 1'b0;
			stage2_pixel <= '0;
		end else if (advance) begin
			stage2_valid <= stage1_valid;
			stage2_pixel <= next_pixel;
		end
	end

	// Free-running pixel counters, wrap at full range
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_count <= '0;
		end else if (color_corrected_valid && color_corrected_ready) begin
			in_count <= in_count + DATA_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_count <= '0;
		end else if (tone_valid && tone_ready) begin
			out_count <= out_count + DATA_W'(1);
		end
	end

	assign fifo_fill.valid = stage2_valid;
	assign fifo_fill.data = stage2_pixel;
	assign fifo_drain.ready = tone_ready;
	assign tone_valid = fifo_drain.valid;
	assign tone_pixel = fifo_drain.data;

	pixel_fifo #(
		.WIDTH(PIX_OUT_W),
		.DEPTH(FIFO_DEPTH),
		.CNT_W(FIFO_CNT_W)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.fill(fifo_fill),
		.drain(fifo_drain),
		.level(fifo_level)
	);
endmodule : tone_curve_interpolator

// >>> bench/tone_curve_asserts.sv
`timescale 1ns/1ps
module tone_curve_asserts (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [tone_curve_pkg::DATA_W-1:0] rdata,
	// Pixel streams
	input wire logic color_corrected_valid,
	input wire logic color_corrected_ready,
	input wire logic tone_valid,
	input wire logic tone_ready,
	input wire logic [tone_curve_pkg::PIX_OUT_W-1:0] tone_pixel
);
	import tone_curve_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire take = color_corrected_valid && color_corrected_ready;
	wire both = awvalid && awready && wvalid && wready;

	chk_pipe_latency: assert property (take |-> ##3 tone_valid)
		else $error("pixel did not reach the output in three cycles");
	chk_out_origin: assert property ($rose(tone_valid) |-> $past(take, 3))
		else $error("output appeared without a matching input");
	chk_out_hold: assert property (tone_valid && !tone_ready |=>
		tone_valid && $stable(tone_pixel))
		else $error("stalled output pixel changed");
	chk_write_resp: assert property (both |-> ##2 bvalid)
		else $error("write response late");
	chk_bresp_hold: assert property (bvalid && !bready |=>
		bvalid && $stable(bresp))
		else $error("write response dropped early");
	chk_read_resp: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	chk_rdata_hold: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata))
		else $error("read data dropped early");
	chk_bus_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	chk_read_refuse: assert property (rvalid |-> !arready)
		else $error("read taken while data pending");

	cover property (take && !tone_ready);
	cover property (color_corrected_valid && !color_corrected_ready);
	cover property (bvalid && bresp == RESP_SLVERR);
endmodule : tone_curve_asserts

bind tone_curve_interpolator tone_curve_asserts tone_curve_asserts_i (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
	.color_corrected_valid, .color_corrected_ready, .tone_valid,
	.tone_ready, .tone_pixel
);

// >>> bench/pixel_sink.sv
`timescale 1ns/1ps
module pixel_sink (
	// Clock and stall control
	input wire logic aclk,
	input wire logic stall,
	// Pixel stream from the stage
	input wire logic tone_valid,
	output logic tone_ready,
	input wire logic [tone_curve_pkg::PIX_OUT_W-1:0] tone_pixel
);
	import tone_curve_pkg::*;
	logic [PIX_OUT_W-1:0] got[$];
	// Stall stands in for a busy downstream stage
	assign tone_ready = !stall;
	// Arrival order kept so order and count can be judged
	always @(posedge aclk) begin
		if (tone_valid && tone_ready) got.push_back(tone_pixel);
	end
endmodule : pixel_sink

// >>> bench/tone_curve_interpolator_test.sv
`timescale 1ns/1ps
module tone_curve_interpolator_test;
	import tone_curve_pkg::*;
	logic aclk, aresetn, stall;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic color_corrected_valid, color_corrected_ready;
	logic tone_valid, tone_ready;
	logic [PIX_IN_W-1:0] color_corrected_pixel;
	logic [PIX_OUT_W-1:0] tone_pixel;
	logic [PIX_OUT_W-1:0] exp_q[$];
	logic [1:0] modes[3] = '{2'h2, 2'h1, 2'h3};
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;

	tone_curve_interpolator tone_curve_interpolator_i (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
		.wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
		.rdata, .rresp, .color_corrected_valid, .color_corrected_ready,
		.color_corrected_pixel, .tone_valid, .tone_ready, .tone_pixel
	);
	pixel_sink pixel_sink_i (.aclk, .stall, .tone_valid, .tone_ready,
		.tone_pixel);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task stop_test;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test

	// Ceiling well above the expected run of about 900 cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 8000) begin
			err_count++;
			stop_test();
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Responses are always accepted at once, so bready stays high
	task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) ad = 1'b1;
			if (wvalid && wready) wd = 1'b1;
			if (ad) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
		end while (!(ad && wd));
		do @(posedge aclk); while (!bvalid);
		check(32'(bresp), 32'(er));
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, exp, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		check(rdata, exp);
		check(32'(rresp), 32'(er));
	endtask : rd_chk

	function automatic logic [9:0] curve(int c, logic [11:0] v);
		int s, r;
		s = int'(v[11:6]) - 32;
		r = int'(v[11:6]) * 16 + c * 5 + ((s * int'(v[5:0])) >>> 6);
		if (r < 0) r = 0;
		if (r > 1023) r = 1023;
		return 10'(r);
	endfunction : curve

	function automatic logic [31:0] entry(int c, int i);
		return {6'h00, 10'(i * 16 + c * 5), 6'h00, 10'(i - 32)};
	endfunction : entry

	function automatic logic [29:0] expect_pix(logic [1:0] m, logic [35:0] p);
		if (!m[0]) return p[29:0];
		if (!m[1]) return {p[35:26], p[23:14], p[11:2]};
		return {curve(0, p[35:24]), curve(1, p[23:12]), curve(2, p[11:0])};
	endfunction : expect_pix

	function automatic logic [35:0] pix(int k);
		return {12'hFFF - 12'(k * 211), 12'(k * 203 + 63), 12'(k * 421)};
	endfunction : pix

	// Valid is left high between pixels to avoid a double assignment
	task automatic send(input logic [35:0] p, input logic [1:0] m);
		color_corrected_pixel <= p;
		color_corrected_valid <= 1'b1;
		do @(posedge aclk); while (!color_corrected_ready);
		exp_q.push_back(expect_pix(m, p));
	endtask : send

	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b1;
		rready = 1'b1;
		stall = 1'b0;
		awaddr = 32'h0;
		araddr = 32'h0;
		wdata = 32'h0;
		color_corrected_valid = 1'b0;
		color_corrected_pixel = 36'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(ADDR_CTRL, 32'h0, RESP_OKAY);
		rd_chk(32'hF000_80A0, 32'h0, RESP_SLVERR);
		wr(ADDR_IN_COUNT, 32'h0, RESP_SLVERR);
		for (int c = 0; c < 3; c++) begin
			wr(ADDR_INDEX, 32'h0, RESP_OKAY);
			for (int i = 0; i < 64; i++)
				wr(ADDR_RED + 32'(4 * c), entry(c, i), RESP_OKAY);
		end
		wr(ADDR_INDEX, 32'h9, RESP_OKAY);
		for (int c = 0; c < 3; c++)
			rd_chk(ADDR_RED + 32'(4 * c), entry(c, 9), RESP_OKAY);
		for (int j = 0; j < 3; j++) begin
			wr(ADDR_CTRL, 32'(modes[j]), RESP_OKAY);
			stall <= 1'b1;
			fork
				for (int k = 0; k < 20; k++) send(pix(k), modes[j]);
				begin
					repeat (40) @(posedge aclk);
					check(32'(color_corrected_ready), 32'h0);
					rd_chk(ADDR_STATUS, 32'h110, RESP_OKAY);
					stall <= 1'b0;
				end
			join
			color_corrected_valid <= 1'b0;
			repeat (40) @(posedge aclk);
			check(32'(pixel_sink_i.got.size()), 32'd20);
			for (int k = 0; k < 20; k++)
				check(32'(pixel_sink_i.got[k]), 32'(exp_q[k]));
			rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
			exp_q.delete();
			pixel_sink_i.got.delete();
		end
		stop_test();
	end
endmodule : tone_curve_interpolator_test
